// ### rtl/csd_clk_div.sv
// Glitch-free clock enable divider producing one-cycle pulses
`timescale 1ns/1ps
module csd_clk_div #(
	parameter int WIDTH = 8
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic src_en_in,
	input wire logic [WIDTH-1:0] ratio_in,
	output logic tick_out
);
	logic [WIDTH-1:0] cnt_r, cnt_nxt;
	logic [WIDTH-1:0] ratio_r, ratio_nxt;
	logic tick_nxt;

	if (WIDTH < 1 || WIDTH > 16)
	begin : g_bad_width
		$error("csd_clk_div WIDTH out of range");
	end

	always_comb
	begin
		cnt_nxt = cnt_r;
		ratio_nxt = ratio_r;
		tick_nxt = 1'b0;
		if (src_en_in)
		begin
			// Ratio changes only at a period boundary
			if (cnt_r == '0)
			begin
				tick_nxt = 1'b1;
				ratio_nxt = (ratio_in == '0) ? WIDTH'(1) : ratio_in;
				cnt_nxt = ratio_nxt - WIDTH'(1);
			end
			else
				cnt_nxt = cnt_r - WIDTH'(1);
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			cnt_r <= '0;
			ratio_r <= WIDTH'(1);
			tick_out <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			ratio_r <= ratio_nxt;
			tick_out <= tick_nxt;
		end
	end
endmodule : csd_clk_div

// ### rtl/csd_glitch_mux.sv
// Two-input enable mux that switches only between source pulses
`timescale 1ns/1ps
module csd_glitch_mux (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic sel_in,
	input wire logic a_in,
	input wire logic b_in,
	output logic y_out
);
	logic sel_r, sel_nxt;
	logic y_nxt;

	always_comb
	begin
		sel_nxt = sel_r;
		// Switch at an old pulse or a gap in the new
		// A full-rate source never has a gap, so its pulse is the boundary
		if ((sel_r ? b_in : a_in) || !(sel_r ? a_in : b_in))
			sel_nxt = sel_in;
		y_nxt = sel_r ? b_in : a_in;
	end

	always_ff @(posedge clk_in)
	begin
		if (!nrst_in)
		begin
			sel_r <= 1'b0;
			y_out <= 1'b0;
		end
		else
		begin
			sel_r <= sel_nxt;
			y_out <= y_nxt;
		end
	end
endmodule : csd_glitch_mux

// ### rtl/csd_params.svh
// Register map, field positions and reset values of the clock control block
`ifndef CSD_PARAMS_SVH
`define CSD_PARAMS_SVH
`define CSD_ADDR_SRC 32'h4C000020
`define CSD_ADDR_DIV0 32'h4C000024
`define CSD_ADDR_DIV1 32'h4C000028
`define CSD_ADDR_HGATE 32'h4C000030
`define CSD_ADDR_PGATE 32'h4C000034
`define CSD_ADDR_SGATE 32'h4C000038
`define CSD_ADDR_STAT 32'h4C00003C
`define CSD_RST_SRC 32'h00000000
`define CSD_RST_DIV0 32'h0000000C
`define CSD_RST_DIV1 32'h00000000
`define CSD_RST_HGATE 32'hFFFFFFFF
`define CSD_RST_PGATE 32'hFFFFFFBF
`define CSD_RST_SGATE 32'hFFFFFFFF
`define CSD_SRC_MASK 32'h0000C1D8
`define CSD_DIV0_MASK 32'h00003FFF
`define CSD_RESP_OKAY 2'h0
`define CSD_RESP_SLVERR 2'h2
`define CSD_F_I2S_HI 15
`define CSD_F_I2S_LO 14
`define CSD_F_ESRC_HI 8
`define CSD_F_ESRC_LO 7
`define CSD_F_SELE 6
`define CSD_F_SELM 4
`define CSD_F_EXTEN 3
`define CSD_F_DVS 13
`define CSD_F_CORE_HI 12
`define CSD_F_CORE_LO 9
`define CSD_F_EXTD_HI 8
`define CSD_F_EXTD_LO 6
`define CSD_F_PRE_HI 5
`define CSD_F_PRE_LO 4
`define CSD_F_HALF 3
`define CSD_F_PLL_PRE_DIVIDER 2
`define CSD_F_HDIV_HI 1
`define CSD_F_HDIV_LO 0
`define CSD_PLL_M_OFS 8
`define CSD_PLL_P_OFS 2
`endif

// ### rtl/csd_pkg.sv
// Types shared by the clock source and divider control block
package csd_pkg;
	typedef logic [31:0] csd_word_t;
	typedef enum logic [1:0]
	{
		CSD_I2S_SECOND_PLL_DIV = 2'h0,
		CSD_I2S_EXT = 2'h1,
		CSD_I2S_REF = 2'h2
	} csd_i2s_e;
	typedef enum logic [1:0]
	{
		CSD_W_IDLE = 2'h0,
		CSD_W_RESP = 2'h1
	} csd_wstate_e;
endpackage : csd_pkg

// ### rtl/csd_top.sv
// Clock source select and divider control with AXI4-Lite registers
`timescale 1ns/1ps
`include "csd_params.svh"
module csd_top (
	input wire logic REF_CLK_IN,
	input wire logic NRST_IN,
	input wire logic MAIN_REF_EN_IN,
	input wire logic CRYSTAL_EN_IN,
	input wire logic EXT_CLK_EN_IN,
	input wire logic MAIN_PLL_EN_IN,
	input wire logic SECOND_PLL_EN_IN,
	input wire logic SECOND_PLL_DIV_EN_IN,
	input wire logic EXT_AUDIO_EN_IN,
	input wire logic [7:0] PLL_MAIN_DIVIDER_IN,
	input wire logic [5:0] PLL_PRE_DIVIDER_IN,
	input wire logic [1:0] PLL_POST_DIVIDER_IN,
	input wire logic [31:0] AWADDR_IN,
	input wire logic AWVALID_IN,
	output logic AWREADY_OUT,
	input wire logic [31:0] WDATA_IN,
	input wire logic [3:0] WSTRB_IN,
	input wire logic WVALID_IN,
	output logic WREADY_OUT,
	output logic [1:0] BRESP_OUT,
	output logic BVALID_OUT,
	input wire logic BREADY_IN,
	input wire logic [31:0] ARADDR_IN,
	input wire logic ARVALID_IN,
	output logic ARREADY_OUT,
	output logic [31:0] RDATA_OUT,
	output logic [1:0] RRESP_OUT,
	output logic RVALID_OUT,
	input wire logic RREADY_IN,
	output logic CORE_CLOCK_EN_OUT,
	output logic AHB_CLOCK_EN_OUT,
	output logic APB_CLOCK_EN_OUT,
	output logic MEM_CLOCK_EN_OUT,
	output logic AUDIO_CLOCK_EN_OUT,
	output logic SECOND_SYSCLK_EN_OUT,
	output logic SECOND_PLL_REF_EN_OUT,
	output logic [31:0] AHB_GATE_OUT,
	output logic [31:0] APB_GATE_OUT,
	output logic [31:0] SPECIAL_GATE_OUT,
	output logic [31:0] SECOND_PLL_FOUT_NUM_OUT,
	output logic [7:0] SECOND_PLL_FOUT_DEN_OUT
);
	import csd_pkg::*;

	csd_word_t src_r, src_nxt;
	csd_word_t div0_r, div0_nxt;
	csd_word_t div1_r, div1_nxt;
	csd_word_t hgate_r, hgate_nxt;
	csd_word_t pgate_r, pgate_nxt;
	csd_word_t sgate_r, sgate_nxt;
	csd_wstate_e ws_r, ws_nxt;
	logic [31:0] aw_r, aw_nxt;
	logic [31:0] wd_r, wd_nxt;
	logic [3:0] ws4_r, ws4_nxt;
	logic aw_have_r, aw_have_nxt;
	logic wd_have_r, wd_have_nxt;
	logic [1:0] bresp_nxt;
	logic bvalid_nxt;
	logic [31:0] rdata_nxt;
	logic [1:0] rresp_nxt;
	logic rvalid_nxt;
	logic awready_nxt, wready_nxt, arready_nxt;
	logic bad_div_r, bad_div_nxt;

	// Merge write data into a register under byte strobes
	function automatic csd_word_t merge(csd_word_t old, csd_word_t d,
		logic [3:0] s, csd_word_t mask);
		csd_word_t r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (s[i])
				r[i*8 +: 8] = d[i*8 +: 8];
		return r & mask;
	endfunction : merge

	// Core divider code to ratio, zero if illegal
	function automatic logic [4:0] core_ratio(logic [3:0] c);
		unique case (c)
			4'h0: return 5'h01;
			4'h8: return 5'h02;
			4'h2: return 5'h03;
			4'h9: return 5'h04;
			4'hA: return 5'h06;
			4'hB: return 5'h08;
			4'hD: return 5'h0C;
			4'hF: return 5'h10;
			default: return 5'h00;
		endcase
	endfunction : core_ratio

	function automatic logic [31:0] read_reg(logic [31:0] a);
		unique case (a)
			`CSD_ADDR_SRC: return src_r;
			`CSD_ADDR_DIV0: return div0_r;
			`CSD_ADDR_DIV1: return div1_r;
			`CSD_ADDR_HGATE: return hgate_r;
			`CSD_ADDR_PGATE: return pgate_r;
			`CSD_ADDR_SGATE: return sgate_r;
			`CSD_ADDR_STAT: return {31'h0, bad_div_r};
			default: return 32'h0;
		endcase
	endfunction : read_reg

	function automatic logic addr_ok(logic [31:0] a);
		return a == `CSD_ADDR_SRC || a == `CSD_ADDR_DIV0 ||
			a == `CSD_ADDR_DIV1 || a == `CSD_ADDR_HGATE ||
			a == `CSD_ADDR_PGATE || a == `CSD_ADDR_SGATE ||
			a == `CSD_ADDR_STAT;
	endfunction : addr_ok

	// Write channel: address and data taken in either order
	always_comb
	begin
		src_nxt = src_r;
		div0_nxt = div0_r;
		div1_nxt = div1_r;
		hgate_nxt = hgate_r;
		pgate_nxt = pgate_r;
		sgate_nxt = sgate_r;
		ws_nxt = ws_r;
		aw_nxt = aw_r;
		wd_nxt = wd_r;
		ws4_nxt = ws4_r;
		aw_have_nxt = aw_have_r;
		wd_have_nxt = wd_have_r;
		bresp_nxt = BRESP_OUT;
		bvalid_nxt = BVALID_OUT;
		unique case (ws_r)
			CSD_W_IDLE:
			begin
				if (AWVALID_IN && AWREADY_OUT)
				begin
					aw_nxt = AWADDR_IN;
					aw_have_nxt = 1'b1;
				end
				if (WVALID_IN && WREADY_OUT)
				begin
					wd_nxt = WDATA_IN;
					ws4_nxt = WSTRB_IN;
					wd_have_nxt = 1'b1;
				end
				if (aw_have_r && wd_have_r)
				begin
					bresp_nxt = addr_ok(aw_r) ? `CSD_RESP_OKAY
						: `CSD_RESP_SLVERR;
					unique case (aw_r)
						`CSD_ADDR_SRC: src_nxt = merge(src_r, wd_r,
							ws4_r, `CSD_SRC_MASK);
						`CSD_ADDR_DIV0: div0_nxt = merge(div0_r, wd_r,
							ws4_r, `CSD_DIV0_MASK);
						`CSD_ADDR_DIV1: div1_nxt = merge(div1_r, wd_r,
							ws4_r, 32'hFFFFFFFF);
						`CSD_ADDR_HGATE: hgate_nxt = merge(hgate_r, wd_r,
							ws4_r, 32'hFFFFFFFF);
						`CSD_ADDR_PGATE: pgate_nxt = merge(pgate_r, wd_r,
							ws4_r, 32'hFFFFFFFF);
						`CSD_ADDR_SGATE: sgate_nxt = merge(sgate_r, wd_r,
							ws4_r, 32'hFFFFFFFF);
						default: ;
					endcase
					bvalid_nxt = 1'b1;
					aw_have_nxt = 1'b0;
					wd_have_nxt = 1'b0;
					ws_nxt = CSD_W_RESP;
				end
			end
			CSD_W_RESP:
			begin
				if (BREADY_IN)
				begin
					bvalid_nxt = 1'b0;
					ws_nxt = CSD_W_IDLE;
				end
			end
		endcase
		awready_nxt = (ws_nxt == CSD_W_IDLE) && !aw_have_nxt;
		wready_nxt = (ws_nxt == CSD_W_IDLE) && !wd_have_nxt;
	end

	// Read channel answers one cycle after the address
	always_comb
	begin
		rdata_nxt = RDATA_OUT;
		rresp_nxt = RRESP_OUT;
		rvalid_nxt = RVALID_OUT;
		if (RVALID_OUT && RREADY_IN)
			rvalid_nxt = 1'b0;
		if (ARVALID_IN && ARREADY_OUT)
		begin
			rdata_nxt = read_reg(ARADDR_IN);
			rresp_nxt = addr_ok(ARADDR_IN) ? `CSD_RESP_OKAY
				: `CSD_RESP_SLVERR;
			rvalid_nxt = 1'b1;
		end
		arready_nxt = !rvalid_nxt;
	end

	always_ff @(posedge REF_CLK_IN)
	begin
		if (!NRST_IN)
		begin
			src_r <= `CSD_RST_SRC;
			div0_r <= `CSD_RST_DIV0;
			div1_r <= `CSD_RST_DIV1;
			hgate_r <= `CSD_RST_HGATE;
			pgate_r <= `CSD_RST_PGATE;
			sgate_r <= `CSD_RST_SGATE;
			ws_r <= CSD_W_IDLE;
			aw_r <= 32'h0;
			wd_r <= 32'h0;
			ws4_r <= 4'h0;
			aw_have_r <= 1'b0;
			wd_have_r <= 1'b0;
			BRESP_OUT <= `CSD_RESP_OKAY;
			BVALID_OUT <= 1'b0;
			RDATA_OUT <= 32'h0;
			RRESP_OUT <= `CSD_RESP_OKAY;
			RVALID_OUT <= 1'b0;
			AWREADY_OUT <= 1'b1;
			WREADY_OUT <= 1'b1;
			ARREADY_OUT <= 1'b1;
		end
		else
		begin
			src_r <= src_nxt;
			div0_r <= div0_nxt;
			div1_r <= div1_nxt;
			hgate_r <= hgate_nxt;
			pgate_r <= pgate_nxt;
			sgate_r <= sgate_nxt;
			ws_r <= ws_nxt;
			aw_r <= aw_nxt;
			wd_r <= wd_nxt;
			ws4_r <= ws4_nxt;
			aw_have_r <= aw_have_nxt;
			wd_have_r <= wd_have_nxt;
			BRESP_OUT <= bresp_nxt;
			BVALID_OUT <= bvalid_nxt;
			RDATA_OUT <= rdata_nxt;
			RRESP_OUT <= rresp_nxt;
			RVALID_OUT <= rvalid_nxt;
			AWREADY_OUT <= awready_nxt;
			WREADY_OUT <= wready_nxt;
			ARREADY_OUT <= arready_nxt;
		end
	end

	logic ref_div_tick, main_ref_tick, main_sys_tick, sec_ref_tick;
	logic sec_sys_tick, ahb_tick, core_div_tick, core_tick;
	logic apb_tick, mem_tick, audio_tick;
	logic sec_ref_pre, audio_pre;
	logic [4:0] cr;
	logic [4:0] ahb_ratio;

	// Reference divide by twice the field plus one
	csd_clk_div #(.WIDTH(4)) u_ref_div (
		.clk_in(REF_CLK_IN),
		.nrst_in(NRST_IN),
		.src_en_in(MAIN_REF_EN_IN),
		.ratio_in({div0_r[`CSD_F_EXTD_HI:`CSD_F_EXTD_LO], 1'b1}),
		.tick_out(ref_div_tick)
	);

	csd_glitch_mux u_ref_mux (.clk_in(REF_CLK_IN), .nrst_in(NRST_IN),
		.sel_in(src_r[`CSD_F_EXTEN]), .a_in(MAIN_REF_EN_IN),
		.b_in(ref_div_tick), .y_out(main_ref_tick));

	// Main system clock: reference or main PLL
	csd_glitch_mux u_msys_mux (.clk_in(REF_CLK_IN), .nrst_in(NRST_IN),
		.sel_in(src_r[`CSD_F_SELM]), .a_in(main_ref_tick),
		.b_in(MAIN_PLL_EN_IN), .y_out(main_sys_tick));

	// Crystal for 10, external for 11, else main reference
	csd_glitch_mux u_eref_xe (.clk_in(REF_CLK_IN), .nrst_in(NRST_IN),
		.sel_in(src_r[`CSD_F_ESRC_LO]), .a_in(CRYSTAL_EN_IN),
		.b_in(EXT_CLK_EN_IN), .y_out(sec_ref_pre));
	csd_glitch_mux u_eref_mux (.clk_in(REF_CLK_IN), .nrst_in(NRST_IN),
		.sel_in(src_r[`CSD_F_ESRC_HI]), .a_in(main_ref_tick),
		.b_in(sec_ref_pre), .y_out(sec_ref_tick));

	// Second system clock: reference or second PLL
	csd_glitch_mux u_esys_mux (.clk_in(REF_CLK_IN), .nrst_in(NRST_IN),
		.sel_in(src_r[`CSD_F_SELE]), .a_in(sec_ref_tick),
		.b_in(SECOND_PLL_EN_IN), .y_out(sec_sys_tick));

	// Audio: divided PLL, external, or reference
	csd_glitch_mux u_aud_lo (.clk_in(REF_CLK_IN), .nrst_in(NRST_IN),
		.sel_in(src_r[`CSD_F_I2S_LO]), .a_in(SECOND_PLL_DIV_EN_IN),
		.b_in(EXT_AUDIO_EN_IN), .y_out(audio_pre));
	csd_glitch_mux u_aud_mux (.clk_in(REF_CLK_IN), .nrst_in(NRST_IN),
		.sel_in(src_r[`CSD_F_I2S_HI]), .a_in(audio_pre),
		.b_in(sec_ref_tick), .y_out(audio_tick));

	// AHB ratio is pre plus one times divider plus one
	// Five-bit terms so a ratio of 16 does not wrap
	assign ahb_ratio = (5'(div0_r[`CSD_F_PRE_HI:`CSD_F_PRE_LO]) + 5'h1) *
		(5'(div0_r[`CSD_F_HDIV_HI:`CSD_F_HDIV_LO]) + 5'h1);
	csd_clk_div #(.WIDTH(5)) u_ahb_div (.clk_in(REF_CLK_IN),
		.nrst_in(NRST_IN), .src_en_in(main_sys_tick),
		.ratio_in(ahb_ratio), .tick_out(ahb_tick));

	// Illegal codes fall back to full rate
	assign cr = core_ratio(div0_r[`CSD_F_CORE_HI:`CSD_F_CORE_LO]);
	csd_clk_div #(.WIDTH(5)) u_core_div (.clk_in(REF_CLK_IN),
		.nrst_in(NRST_IN), .src_en_in(main_sys_tick),
		.ratio_in(cr), .tick_out(core_div_tick));

	// Voltage scaling runs core at AHB rate
	csd_glitch_mux u_core_mux (.clk_in(REF_CLK_IN), .nrst_in(NRST_IN),
		.sel_in(div0_r[`CSD_F_DVS]), .a_in(core_div_tick),
		.b_in(ahb_tick), .y_out(core_tick));

	// Peripheral clock equal or half of AHB
	csd_clk_div #(.WIDTH(2)) u_apb_div (.clk_in(REF_CLK_IN),
		.nrst_in(NRST_IN), .src_en_in(ahb_tick),
		.ratio_in({div0_r[`CSD_F_PLL_PRE_DIVIDER], ~div0_r[`CSD_F_PLL_PRE_DIVIDER]}),
		.tick_out(apb_tick));

	// Static memory clock equal or half of AHB
	csd_clk_div #(.WIDTH(2)) u_mem_div (.clk_in(REF_CLK_IN),
		.nrst_in(NRST_IN), .src_en_in(ahb_tick),
		.ratio_in({div0_r[`CSD_F_HALF], ~div0_r[`CSD_F_HALF]}),
		.tick_out(mem_tick));

	// Status flag: illegal core divider code or AHB divider code 2
	always_comb
	begin
		bad_div_nxt = (cr == 5'h00) ||
			(div0_r[`CSD_F_HDIV_HI:`CSD_F_HDIV_LO] == 2'h2);
	end

	always_ff @(posedge REF_CLK_IN)
	begin
		if (!NRST_IN)
		begin
			bad_div_r <= 1'b0;
			CORE_CLOCK_EN_OUT <= 1'b0;
			AHB_CLOCK_EN_OUT <= 1'b0;
			APB_CLOCK_EN_OUT <= 1'b0;
			MEM_CLOCK_EN_OUT <= 1'b0;
			AUDIO_CLOCK_EN_OUT <= 1'b0;
			SECOND_SYSCLK_EN_OUT <= 1'b0;
			SECOND_PLL_REF_EN_OUT <= 1'b0;
			AHB_GATE_OUT <= `CSD_RST_HGATE;
			APB_GATE_OUT <= `CSD_RST_PGATE;
			SPECIAL_GATE_OUT <= `CSD_RST_SGATE;
			SECOND_PLL_FOUT_NUM_OUT <= 32'h0;
			SECOND_PLL_FOUT_DEN_OUT <= 8'h0;
		end
		else
		begin
			bad_div_r <= bad_div_nxt;
			CORE_CLOCK_EN_OUT <= core_tick;
			AHB_CLOCK_EN_OUT <= ahb_tick;
			APB_CLOCK_EN_OUT <= apb_tick;
			MEM_CLOCK_EN_OUT <= mem_tick;
			AUDIO_CLOCK_EN_OUT <= audio_tick;
			SECOND_SYSCLK_EN_OUT <= sec_sys_tick;
			SECOND_PLL_REF_EN_OUT <= sec_ref_tick;
			AHB_GATE_OUT <= hgate_r;
			APB_GATE_OUT <= pgate_r;
			SPECIAL_GATE_OUT <= sgate_r;
			// Fout = Fin*num / den, with the post shift already applied in den
			SECOND_PLL_FOUT_NUM_OUT <= {24'h0, PLL_MAIN_DIVIDER_IN} +
				32'(`CSD_PLL_M_OFS);
			SECOND_PLL_FOUT_DEN_OUT <= 8'(({2'h0, PLL_PRE_DIVIDER_IN} +
				8'(`CSD_PLL_P_OFS)) << PLL_POST_DIVIDER_IN);
		end
	end
endmodule : csd_top

// ### tb/csd_top_asserts.sv
// Bus, reset and divider-equation checks bound to the block top
`timescale 1ns/1ps
`include "csd_params.svh"
module csd_top_asserts (
	input wire logic REF_CLK_IN,
	input wire logic NRST_IN,
	input wire logic [7:0] PLL_MAIN_DIVIDER_IN,
	input wire logic [5:0] PLL_PRE_DIVIDER_IN,
	input wire logic [1:0] PLL_POST_DIVIDER_IN,
	input wire logic [31:0] AWADDR_IN,
	input wire logic AWVALID_IN,
	input wire logic AWREADY_OUT,
	input wire logic WVALID_IN,
	input wire logic WREADY_OUT,
	input wire logic [1:0] BRESP_OUT,
	input wire logic BVALID_OUT,
	input wire logic BREADY_IN,
	input wire logic [31:0] ARADDR_IN,
	input wire logic ARVALID_IN,
	input wire logic ARREADY_OUT,
	input wire logic [31:0] RDATA_OUT,
	input wire logic [1:0] RRESP_OUT,
	input wire logic RVALID_OUT,
	input wire logic RREADY_IN,
	input wire logic CORE_CLOCK_EN_OUT,
	input wire logic [31:0] SECOND_PLL_FOUT_NUM_OUT,
	input wire logic [7:0] SECOND_PLL_FOUT_DEN_OUT
);
	logic wr_t;
	logic ar_t;
	assign wr_t = AWVALID_IN && AWREADY_OUT && WVALID_IN && WREADY_OUT;
	assign ar_t = ARVALID_IN && ARREADY_OUT;
	default clocking cb @(posedge REF_CLK_IN);
	endclocking
	default disable iff (!NRST_IN);
	property p_bhold;
		BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT);
	endproperty
	a_bhold: assert property (p_bhold)
		else $error("write response dropped");
	property p_rhold;
		RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT)
			&& $stable(RRESP_OUT);
	endproperty
	a_rhold: assert property (p_rhold)
		else $error("read response dropped");
	property p_blat;
		wr_t |=> !BVALID_OUT ##1 BVALID_OUT;
	endproperty
	a_blat: assert property (p_blat)
		else $error("write response not two cycles after capture");
	property p_rlat;
		ar_t |=> RVALID_OUT;
	endproperty
	a_rlat: assert property (p_rlat)
		else $error("read data not one cycle after address");
	property p_wbusy;
		BVALID_OUT |-> !AWREADY_OUT && !WREADY_OUT;
	endproperty
	a_wbusy: assert property (p_wbusy)
		else $error("write accepted while response pending");
	property p_rbusy;
		RVALID_OUT |-> !ARREADY_OUT;
	endproperty
	a_rbusy: assert property (p_rbusy)
		else $error("read accepted while data pending");
	property p_rerr;
		ar_t && ARADDR_IN == 32'h4C00002C |=>
			RRESP_OUT == `CSD_RESP_SLVERR && RDATA_OUT == 32'h0;
	endproperty
	a_rerr: assert property (p_rerr)
		else $error("unmapped read not refused");
	property p_werr;
		wr_t && AWADDR_IN == 32'h4C00002C |-> ##2 BRESP_OUT == `CSD_RESP_SLVERR;
	endproperty
	a_werr: assert property (p_werr)
		else $error("unmapped write not refused");
	property p_rst;
		$rose(NRST_IN) |-> !BVALID_OUT && !RVALID_OUT && AWREADY_OUT
			&& ARREADY_OUT && !CORE_CLOCK_EN_OUT;
	endproperty
	a_rst: assert property (p_rst)
		else $error("outputs not idle after reset");
	// Registered one cycle behind the divider inputs
	property p_pll;
		$past(NRST_IN) |-> SECOND_PLL_FOUT_NUM_OUT ==
			32'($past(PLL_MAIN_DIVIDER_IN)) + 32'h8 && SECOND_PLL_FOUT_DEN_OUT
			== 8'((8'($past(PLL_PRE_DIVIDER_IN)) + 8'h2)
			<< $past(PLL_POST_DIVIDER_IN));
	endproperty
	a_pll: assert property (p_pll)
		else $error("second pll ratio wrong");
	c_write: cover property (wr_t);
	c_rerr: cover property (ar_t ##1 RRESP_OUT == `CSD_RESP_SLVERR);
	c_werr: cover property (BVALID_OUT && BRESP_OUT == `CSD_RESP_SLVERR);
endmodule : csd_top_asserts
bind csd_top csd_top_asserts u_csd_top_asserts (
	.REF_CLK_IN, .NRST_IN, .PLL_MAIN_DIVIDER_IN, .PLL_PRE_DIVIDER_IN,
	.PLL_POST_DIVIDER_IN, .AWADDR_IN, .AWVALID_IN, .AWREADY_OUT, .WVALID_IN,
	.WREADY_OUT, .BRESP_OUT, .BVALID_OUT, .BREADY_IN, .ARADDR_IN,
	.ARVALID_IN, .ARREADY_OUT, .RDATA_OUT, .RRESP_OUT, .RVALID_OUT,
	.RREADY_IN, .CORE_CLOCK_EN_OUT, .SECOND_PLL_FOUT_NUM_OUT,
	.SECOND_PLL_FOUT_DEN_OUT
);

// ### tb/csd_top_tb.sv
// Self-checking bench for the clock source and divider control block
`timescale 1ns/1ps
`include "csd_params.svh"
`define CHK(a, e) \
	begin \
		n_checks++; \
		if ((a) !== (e)) \
		begin \
			n_errors++; \
			$display("mismatch at %0t: got %h want %h", $time, a, e); \
		end \
	end
module csd_top_tb;
	localparam int W = 420;
	localparam logic [1:0] OK = `CSD_RESP_OKAY;
	localparam logic [1:0] ER = `CSD_RESP_SLVERR;
	localparam logic [31:0] GAP = 32'h4C00002C;
	localparam logic [31:0] D0 = `CSD_ADDR_DIV0;
	int n_errors = 0;
	int n_checks = 0;
	int ph = 0;
	int c[7];
	logic REF_CLK_IN = 1'h0;
	logic NRST_IN = 1'h0;
	logic MAIN_REF_EN_IN = 1'h1;
	logic CRYSTAL_EN_IN = 1'h0, EXT_CLK_EN_IN = 1'h0, MAIN_PLL_EN_IN = 1'h0;
	logic SECOND_PLL_EN_IN = 1'h0, SECOND_PLL_DIV_EN_IN = 1'h0;
	logic EXT_AUDIO_EN_IN = 1'h0;
	logic [7:0] PLL_MAIN_DIVIDER_IN = 8'h28;
	logic [5:0] PLL_PRE_DIVIDER_IN = 6'h1;
	logic [1:0] PLL_POST_DIVIDER_IN = 2'h2;
	logic [31:0] AWADDR_IN = '0, WDATA_IN = '0, ARADDR_IN = '0;
	logic [3:0] WSTRB_IN = '0;
	logic AWVALID_IN = 1'h0, WVALID_IN = 1'h0, BREADY_IN = 1'h0;
	logic ARVALID_IN = 1'h0, RREADY_IN = 1'h0;
	logic AWREADY_OUT, WREADY_OUT, BVALID_OUT, ARREADY_OUT, RVALID_OUT;
	logic [1:0] BRESP_OUT, RRESP_OUT;
	logic [31:0] RDATA_OUT, AHB_GATE_OUT, APB_GATE_OUT, SPECIAL_GATE_OUT;
	logic [31:0] SECOND_PLL_FOUT_NUM_OUT;
	logic [7:0] SECOND_PLL_FOUT_DEN_OUT;
	wire [6:0] en;
	csd_top u_csd_top (
		.REF_CLK_IN, .NRST_IN, .MAIN_REF_EN_IN, .CRYSTAL_EN_IN,
		.EXT_CLK_EN_IN, .MAIN_PLL_EN_IN, .SECOND_PLL_EN_IN,
		.SECOND_PLL_DIV_EN_IN, .EXT_AUDIO_EN_IN, .PLL_MAIN_DIVIDER_IN,
		.PLL_PRE_DIVIDER_IN, .PLL_POST_DIVIDER_IN, .AWADDR_IN, .AWVALID_IN,
		.AWREADY_OUT, .WDATA_IN, .WSTRB_IN, .WVALID_IN, .WREADY_OUT,
		.BRESP_OUT, .BVALID_OUT, .BREADY_IN, .ARADDR_IN, .ARVALID_IN,
		.ARREADY_OUT, .RDATA_OUT, .RRESP_OUT, .RVALID_OUT, .RREADY_IN,
		.CORE_CLOCK_EN_OUT(en[0]), .AHB_CLOCK_EN_OUT(en[1]),
		.APB_CLOCK_EN_OUT(en[2]), .MEM_CLOCK_EN_OUT(en[3]),
		.AUDIO_CLOCK_EN_OUT(en[4]), .SECOND_SYSCLK_EN_OUT(en[5]),
		.SECOND_PLL_REF_EN_OUT(en[6]), .AHB_GATE_OUT, .APB_GATE_OUT,
		.SPECIAL_GATE_OUT, .SECOND_PLL_FOUT_NUM_OUT, .SECOND_PLL_FOUT_DEN_OUT
	);
	always #12.5 REF_CLK_IN = ~REF_CLK_IN;
	// Distinct source periods so every mux leg is recognisable
	always @(posedge REF_CLK_IN)
	begin
		ph <= (ph + 1) % W;
		MAIN_PLL_EN_IN <= ph % 2 == 0;
		SECOND_PLL_EN_IN <= ph % 3 == 0;
		CRYSTAL_EN_IN <= ph % 4 == 0;
		EXT_CLK_EN_IN <= ph % 5 == 0;
		SECOND_PLL_DIV_EN_IN <= ph % 6 == 0;
		EXT_AUDIO_EN_IN <= ph % 7 == 0;
	end
	task automatic final_report;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report
	task automatic tmo(input int k);
		if (k >= 50)
		begin
			n_errors++;
			final_report();
		end
	endtask : tmo
	task automatic wr(input logic [31:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] r);
		int k;
		AWADDR_IN <= a;
		WDATA_IN <= d;
		WSTRB_IN <= s;
		AWVALID_IN <= 1'h1;
		WVALID_IN <= 1'h1;
		BREADY_IN <= 1'h1;
		for (k = 0; k < 50; k++)
		begin
			@(posedge REF_CLK_IN);
			if (AWREADY_OUT) AWVALID_IN <= 1'h0;
			if (WREADY_OUT) WVALID_IN <= 1'h0;
			if (BVALID_OUT) break;
		end
		tmo(k);
		`CHK(BRESP_OUT, r)
		BREADY_IN <= 1'h0;
		@(posedge REF_CLK_IN);
	endtask : wr
	task automatic rd(input logic [31:0] a, input logic [31:0] e,
		input logic [1:0] r, input logic [31:0] m = '1);
		int k;
		ARADDR_IN <= a;
		ARVALID_IN <= 1'h1;
		RREADY_IN <= 1'h1;
		for (k = 0; k < 50; k++)
		begin
			@(posedge REF_CLK_IN);
			if (ARREADY_OUT) ARVALID_IN <= 1'h0;
			if (RVALID_OUT) break;
		end
		tmo(k);
		`CHK(RDATA_OUT & m, e)
		`CHK(RRESP_OUT, r)
		RREADY_IN <= 1'h0;
		@(posedge REF_CLK_IN);
	endtask : rd
	// Settle past the old divider period, then count pulses over W cycles
	task automatic meas;
		int i;
		int j;
		c = '{default: 0};
		repeat (100) @(posedge REF_CLK_IN);
		for (i = 0; i < W; i++)
		begin
			@(posedge REF_CLK_IN);
			for (j = 0; j < 7; j++) c[j] += (en[j] === 1'h1);
		end
	endtask : meas
	task automatic near(input int j, input int p);
		`CHK(c[j] >= W / p - 1 && c[j] <= W / p + 1, 1'h1)
	endtask : near
	task automatic t_reset;
		NRST_IN <= 1'h0;
		repeat (8) @(posedge REF_CLK_IN);
		NRST_IN <= 1'h1;
		@(posedge REF_CLK_IN);
		rd(`CSD_ADDR_SRC, `CSD_RST_SRC, OK);
		rd(D0, `CSD_RST_DIV0, OK);
		rd(`CSD_ADDR_DIV1, `CSD_RST_DIV1, OK);
		rd(`CSD_ADDR_HGATE, `CSD_RST_HGATE, OK);
		rd(`CSD_ADDR_PGATE, `CSD_RST_PGATE, OK);
		rd(`CSD_ADDR_SGATE, `CSD_RST_SGATE, OK);
		`CHK(AHB_GATE_OUT, `CSD_RST_HGATE)
		`CHK(APB_GATE_OUT, `CSD_RST_PGATE)
		`CHK(SPECIAL_GATE_OUT, `CSD_RST_SGATE)
	endtask : t_reset
	task automatic t_regs;
		wr(`CSD_ADDR_SRC, 32'hFFFFFFFF, 4'hF, OK);
		rd(`CSD_ADDR_SRC, `CSD_SRC_MASK, OK);
		wr(D0, 32'hFFFFFFFB, 4'hF, OK);
		rd(D0, 32'h00003FFB, OK);
		wr(`CSD_ADDR_DIV1, 32'hAABBCCDD, 4'hF, OK);
		wr(`CSD_ADDR_DIV1, 32'h00000011, 4'h1, OK);
		rd(`CSD_ADDR_DIV1, 32'hAABBCC11, OK);
		wr(`CSD_ADDR_HGATE, 32'h12345678, 4'hF, OK);
		`CHK(AHB_GATE_OUT, 32'h12345678)
		wr(`CSD_ADDR_PGATE, 32'h0000A5A5, 4'hF, OK);
		`CHK(APB_GATE_OUT, 32'h0000A5A5)
		rd(GAP, 32'h0, ER);
		wr(GAP, 32'hFFFFFFFF, 4'hF, ER);
		wr(D0, 32'h00000200, 4'hF, OK);
		rd(`CSD_ADDR_STAT, 32'h1, OK, 32'h1);
		wr(D0, 32'h00000002, 4'hF, OK);
		rd(`CSD_ADDR_STAT, 32'h1, OK, 32'h1);
		wr(D0, 32'h00001000, 4'hF, OK);
		rd(`CSD_ADDR_STAT, 32'h0, OK, 32'h1);
	endtask : t_regs
	task automatic t_ahb;
		int p;
		int h;
		// Full-rate reference so core and AHB count every cycle
		wr(`CSD_ADDR_SRC, 32'h0, 4'hF, OK);
		// pre-divider kept within 0 to 3
		for (p = 0; p < 4; p++)
			for (h = 0; h < 4; h++)
			begin
				if (h == 2) continue;
				wr(D0, 32'(p * 16 + h), 4'hF, OK);
				meas();
				near(0, 1);
				near(1, (p + 1) * (h + 1));
				near(2, (p + 1) * (h + 1));
				near(3, (p + 1) * (h + 1));
			end
		wr(D0, 32'h0000000D, 4'hF, OK);
		meas();
		near(2, 4);
		near(3, 4);
	endtask : t_ahb
	task automatic t_core;
		int i;
		int cd[8] = '{0, 8, 2, 9, 10, 11, 13, 15};
		int dv[8] = '{1, 2, 3, 4, 6, 8, 12, 16};
		for (i = 0; i < 8; i++)
		begin
			// AHB at one sixteenth keeps core not slower
			wr(D0, 32'(cd[i] * 512) | 32'h33, 4'hF, OK);
			meas();
			near(0, dv[i]);
		end
		wr(D0, 32'h00003E11, 4'hF, OK);
		meas();
		near(0, 4);
		near(1, 4);
	endtask : t_core
	task automatic t_src;
		int i;
		int rp[4] = '{1, 1, 4, 5};
		int ap[4] = '{6, 7, 4, 5};
		wr(D0, 32'h0, 4'hF, OK);
		for (i = 0; i < 4; i++)
		begin
			wr(`CSD_ADDR_SRC, 32'(i * 16384 + i * 128), 4'hF, OK);
			meas();
			near(6, rp[i]);
			near(5, rp[i]);
			near(4, ap[i]);
		end
		wr(`CSD_ADDR_SRC, 32'h8, 4'hF, OK);
		for (i = 0; i < 4; i++)
		begin
			wr(D0, 32'(i * 64), 4'hF, OK);
			meas();
			near(0, 2 * i + 1);
		end
		wr(`CSD_ADDR_SRC, 32'h0, 4'hF, OK);
		meas();
		near(0, 1);
		wr(`CSD_ADDR_SRC, 32'h50, 4'hF, OK);
		meas();
		near(0, 2);
		near(5, 3);
	endtask : t_src
	task automatic t_pll;
		int i;
		int m[4] = '{28, 40, 22, 92};
		int p[4] = '{1, 1, 1, 8};
		int s[4] = '{2, 2, 1, 1};
		for (i = 0; i < 4; i++)
		begin
			PLL_MAIN_DIVIDER_IN <= 8'(m[i]);
			PLL_PRE_DIVIDER_IN <= 6'(p[i]);
			PLL_POST_DIVIDER_IN <= 2'(s[i]);
			repeat (2) @(posedge REF_CLK_IN);
			`CHK(SECOND_PLL_FOUT_NUM_OUT, 32'(m[i] + 8))
			`CHK(SECOND_PLL_FOUT_DEN_OUT, 8'((p[i] + 2) << s[i]))
		end
	endtask : t_pll
	initial
	begin
		t_reset();
		t_regs();
		t_ahb();
		t_core();
		t_src();
		t_pll();
		t_reset();
		final_report();
	end
endmodule : csd_top_tb
